// File: stsp_pkg.sv
// Constants and types of the speech test serial port.
// Assumes a 10 MHz system clock; the port derives the link clock from it.
package stsp_pkg;
  localparam int          SYS_CLK_HZ   = 10_000_000;
  localparam int          LINK_BIT_HZ  = 104_000;
  localparam int          SAMPLE_RATE  = 8000;
  localparam int          WORD_BITS    = 13;
  // Half link period, rounded down so the link never runs slow
  localparam int          HALF_CYC     = SYS_CLK_HZ / (2 * LINK_BIT_HZ);
  // Synchroniser latency before the data pin is read in the high phase
  localparam int          SAMPLE_AT    = 2;
  localparam logic [5:0]  HALF_LAST    = 6'(HALF_CYC - 1);
  localparam logic [5:0]  SAMPLE_CNT   = 6'(SAMPLE_AT);
  localparam logic [3:0]  BIT_LAST     = 4'(WORD_BITS - 1);
  localparam logic [1:0]  MODE_NORMAL  = 2'h0;
  localparam logic [1:0]  MODE_DOWN    = 2'h1;
  localparam logic [1:0]  MODE_UP      = 2'h2;
  localparam logic [1:0]  MODE_ACOUST  = 2'h3;
  localparam logic        SCLK_IDLE    = 1'h1;
  localparam logic [12:0] WORD_RESET   = 13'h0000;

  typedef enum logic [1:0] {ST_IDLE, ST_LOW, ST_HIGH} stsp_state_e;

  typedef struct packed {
    logic up;
    logic down;
  } stsp_mode_s;
endpackage

// File: stsp_port.sv
// Handset end of the speech test serial port: bit clock source, duplex shifter,
// mode decode, transcoder reset and a two-entry buffer toward the encoder.
// Assumes the tester drives mode, reset and data asynchronously to CLOCK_IN.
// Functional notes
// [R1] 13-bit samples, 8000/s, 104 kbit/s per direction
// [R2] Handset clocks only when samples needed/ready
// [R3] Tester drives mode lines and reset
// [R4] Reset line is active low
// [R5] Two's complement words, MSB first
// [R6] Sample on rising, change on falling edge
// [R7] Serial clock held high when idle
// [R8] Mode lines select normal/down/up/acoustic test
// [R9] Mode from pins or message, one declared
// [R10] Tester sets mode, waits, pulses reset
// [R11] Clocking starts after reset release
// [R12] Uplink starts at first block frame (acoustic mode starts on DL_VALID_IN without it)
// [R13] Downlink sends first completed decoded block
// [R14] Transcoders reset when reset pulse ends (normal mode gives no TRANSCODER_RST_OUT pulse)
// [R15] Reset also clears A/D and D/A
// [R16] Thirteen pulses per word, counted from reset
// [R17] Normal mode keeps clock idle
module stsp_port
  import stsp_pkg::*;
#(
  parameter bit USE_MSG_MODE = 1'b0
) (
  input  wire logic        CLOCK_IN,
  input  wire logic        NRST_IN,
  input  wire logic        MODE1_IN,
  input  wire logic        MODE2_IN,
  input  wire logic        TEST_RST_N_IN,
  input  wire logic        TESTER_DATA_IN,
  input  wire logic [1:0]  MSG_MODE_IN,
  input  wire logic        BLOCK_FRAME_IN,
  input  wire logic [12:0] DL_DATA_IN,
  input  wire logic        DL_VALID_IN,
  output logic             DL_READY_OUT,
  output logic [12:0]      UL_DATA_OUT,
  output logic             UL_VALID_OUT,
  input  wire logic        UL_READY_IN,
  output logic             SCLK_OUT,
  output logic             HANDSET_DATA_OUT,
  output logic [1:0]       MODE_OUT,
  output logic             CODEC_RST_OUT,
  output logic             TRANSCODER_RST_OUT
);
  if (HALF_CYC < SAMPLE_AT + 2) begin : g_bad_clock
    $error("System clock too slow for link");
  end

  logic [2:0]  s1_reg, s2_reg;
  logic        din_s1_reg, din_s2_reg;
  logic        trst_d_reg;
  logic [1:0]  mode_pin;
  logic [1:0]  mode_act;
  stsp_mode_s  mode_dec;
  logic        in_reset;
  logic        rst_release;
  logic        frame_seen_reg;
  stsp_state_e state_reg;
  logic [5:0]  half_reg;
  logic [3:0]  bit_reg;
  logic [12:0] tx_sh_reg;
  logic [12:0] rx_sh_reg;
  logic        sclk_reg;
  logic        dout_reg;
  logic        push_reg;
  logic        start;
  logic        buf_space;
  logic [12:0] buf_mem [2];
  logic        wr_ptr_reg, rd_ptr_reg;
  logic [1:0]  count_reg;
  logic        pop;

  // Tester pins are asynchronous: two flops before use
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      s1_reg     <= 3'h4;
      s2_reg     <= 3'h4;
      din_s1_reg <= 1'h0;
      din_s2_reg <= 1'h0;
    end else begin
      s1_reg     <= {TEST_RST_N_IN, MODE2_IN, MODE1_IN};
      s2_reg     <= s1_reg;
      din_s1_reg <= TESTER_DATA_IN;
      din_s2_reg <= din_s1_reg;
    end
  end

  assign mode_pin      = {s2_reg[0], s2_reg[1]};
  assign mode_act      = USE_MSG_MODE ? MSG_MODE_IN : mode_pin; // [R9]
  assign mode_dec.up   = mode_act[1];                           // [R8]
  assign mode_dec.down = mode_act[0];                           // [R8]
  assign MODE_OUT      = mode_act;
  assign in_reset      = !s2_reg[2];                            // [R4]
  assign rst_release   = s2_reg[2] && !trst_d_reg;

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      trst_d_reg         <= 1'h1;
      CODEC_RST_OUT      <= 1'h0;
      TRANSCODER_RST_OUT <= 1'h0;
    end else begin
      trst_d_reg         <= s2_reg[2];
      CODEC_RST_OUT      <= in_reset;                                   // [R15]
      TRANSCODER_RST_OUT <= rst_release && (mode_act != MODE_NORMAL);   // [R14]
    end
  end

  // Uplink mode waits for the first block frame after the reset pulse; acoustic mode does not
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      frame_seen_reg <= 1'h0;
    end else if (in_reset) begin
      frame_seen_reg <= 1'h0;
    end else if (BLOCK_FRAME_IN) begin
      frame_seen_reg <= 1'h1;                                           // [R12]
    end
  end

  // Acoustic test needs both directions at once; normal mode never starts
  // A word still waiting in push_reg already owns a slot
  assign buf_space    = (count_reg == 2'h0) || (count_reg == 2'h1 && !push_reg);
  always_comb begin
    case (mode_act)
      MODE_DOWN:   start = DL_VALID_IN;                                 // [R13]
      MODE_UP:     start = frame_seen_reg && buf_space;                 // [R12]
      MODE_ACOUST: start = DL_VALID_IN && buf_space;
      default:     start = 1'b0;                                        // [R17]
    endcase
  end
  assign DL_READY_OUT = (state_reg == ST_IDLE) && !in_reset && mode_dec.down && start; // [R2] [R11]

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      state_reg <= ST_IDLE;
      half_reg  <= 6'h00;
      bit_reg   <= 4'h0;
      tx_sh_reg <= WORD_RESET;
      rx_sh_reg <= WORD_RESET;
      sclk_reg  <= SCLK_IDLE;
      dout_reg  <= 1'h0;
      push_reg  <= 1'h0;
    end else begin
      push_reg <= 1'h0;
      if (in_reset) begin
        state_reg <= ST_IDLE;                                           // [R16]
        sclk_reg  <= SCLK_IDLE;
        bit_reg   <= 4'h0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            sclk_reg <= SCLK_IDLE;                                      // [R7]
            if (start) begin
              state_reg <= ST_LOW;                                      // [R2] [R11]
              sclk_reg  <= 1'h0;
              half_reg  <= 6'h00;
              bit_reg   <= 4'h0;
              dout_reg  <= mode_dec.down ? DL_DATA_IN[12] : 1'h0;       // [R5] [R6]
              tx_sh_reg <= mode_dec.down ? {DL_DATA_IN[11:0], 1'h0} : WORD_RESET;
            end
          end
          ST_LOW: begin
            half_reg <= half_reg + 6'h01;
            if (half_reg == HALF_LAST) begin
              state_reg <= ST_HIGH;
              sclk_reg  <= 1'h1;
              half_reg  <= 6'h00;
            end
          end
          ST_HIGH: begin
            half_reg <= half_reg + 6'h01;
            if (half_reg == SAMPLE_CNT) begin
              // Pin flops add latency; still inside the hold window after the rise
              rx_sh_reg <= {rx_sh_reg[11:0], din_s2_reg};               // [R6] [R5]
            end
            if (half_reg == HALF_LAST) begin
              half_reg <= 6'h00;
              if (bit_reg == BIT_LAST) begin
                state_reg <= ST_IDLE;                                   // [R16]
                push_reg  <= mode_dec.up;
              end else begin
                state_reg <= ST_LOW;
                sclk_reg  <= 1'h0;
                bit_reg   <= bit_reg + 4'h1;
                dout_reg  <= tx_sh_reg[12];                             // [R6]
                tx_sh_reg <= {tx_sh_reg[11:0], 1'h0};
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  assign SCLK_OUT         = sclk_reg;
  assign HANDSET_DATA_OUT = dout_reg;

  // Two-entry buffer: space is checked at start, so a finished word always fits
  assign pop          = UL_VALID_OUT && UL_READY_IN;
  assign UL_VALID_OUT = (count_reg != 2'h0);
  assign UL_DATA_OUT  = buf_mem[rd_ptr_reg];

  always_ff @(posedge CLOCK_IN) begin
    if (push_reg) begin
      buf_mem[wr_ptr_reg] <= rx_sh_reg;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      wr_ptr_reg <= 1'h0;
      rd_ptr_reg <= 1'h0;
      count_reg  <= 2'h0;
    end else begin
      if (push_reg) wr_ptr_reg <= !wr_ptr_reg;
      if (pop) rd_ptr_reg <= !rd_ptr_reg;
      count_reg <= count_reg + {1'h0, push_reg} - {1'h0, pop};
    end
  end

  // Helper: falling edges seen in the current transfer
  logic [4:0] fall_cnt_reg;
  always_ff @(posedge CLOCK_IN or negedge NRST_IN) begin
    if (!NRST_IN) begin
      fall_cnt_reg <= 5'h00;
    end else if (state_reg == ST_IDLE && start && !in_reset) begin
      fall_cnt_reg <= 5'h01;
    end else if (state_reg == ST_HIGH && half_reg == HALF_LAST && bit_reg != BIT_LAST) begin
      fall_cnt_reg <= fall_cnt_reg + 5'h01;
    end
  end

  clk_idle_high_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R7]
    (state_reg == ST_IDLE) |-> SCLK_OUT)
    else $error("Serial clock low while idle");

  normal_no_clock_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R17]
    (state_reg == ST_IDLE && mode_act == MODE_NORMAL) |=> (state_reg == ST_IDLE))
    else $error("Transfer started in normal mode");

  low_phase_len_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN || in_reset) // [R1]
    $fell(SCLK_OUT) |-> !SCLK_OUT ##47 !SCLK_OUT ##1 SCLK_OUT)
    else $error("Link clock low phase not 48 cycles");

  data_on_fall_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R6]
    $changed(HANDSET_DATA_OUT) |-> $fell(SCLK_OUT))
    else $error("Output data changed away from falling edge");

  word_len_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN || in_reset) // [R16]
    (state_reg == ST_HIGH && half_reg == HALF_LAST && bit_reg == BIT_LAST) |-> (fall_cnt_reg == 5'd13))
    else $error("Word not 13 clock pulses");

  codec_rst_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R15]
    !s2_reg[2] |=> CODEC_RST_OUT)
    else $error("Codec reset not following reset line");

  trans_pulse_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R14]
    (rst_release && mode_act != MODE_NORMAL) |=> TRANSCODER_RST_OUT ##1 !TRANSCODER_RST_OUT)
    else $error("Transcoder reset pulse missing at reset release");

  ul_frame_gate_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R12]
    (state_reg == ST_IDLE && mode_act == MODE_UP && !frame_seen_reg) |=> (state_reg == ST_IDLE))
    else $error("Uplink transfer before block frame");

  dl_msb_first_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R5]
    (DL_READY_OUT && DL_VALID_IN) |=> (HANDSET_DATA_OUT == $past(DL_DATA_IN[12])))
    else $error("Downlink word not sent MSB first");

  rst_no_clock_a: assert property (@(posedge CLOCK_IN) disable iff (!NRST_IN) // [R11]
    in_reset |=> SCLK_OUT)
    else $error("Link clock active during reset");
endmodule

// File: stsp_tester.sv
// Tester model: shifts 13-bit words to and from the handset on its link clock.
// Assumes the bench loads tx_q, reads rx_q and clears nbit between tests.
module stsp_tester (
  input  wire logic sclk_in,
  input  wire logic nrst_in,
  input  wire logic data_in,
  output logic      data_out
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [12:0] tx_q[$];
  logic [12:0] rx_q[$];
  logic [12:0] tx_sr = 13'h0000;
  logic [12:0] rx_sr = 13'h0000;
  int          nbit  = 0;
  initial data_out = 1'b0;
  always @(negedge sclk_in) begin
    if (nbit == 0) tx_sr = (tx_q.size() > 0) ? tx_q.pop_front() : 13'h0000;
    data_out <= tx_sr[12 - nbit];
  end
  always @(posedge sclk_in) begin
    if (nrst_in) begin
      rx_sr = {rx_sr[11:0], data_in};
      if (nbit == 12) begin
        rx_q.push_back(rx_sr);
        nbit = 0;
        // Hold time over: flip the line so a stale bit never reads as valid
        data_out <= #1000 ~tx_sr[0];
      end else nbit++;
    end
  end
endmodule

// File: stsp_port_test.sv
// Bench for the handset speech test port: modes, tester reset, both streams.
// Assumes stsp_tester as the far side and a 10 MHz system clock.
module stsp_port_test;
  import stsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk      = 1'b0;
  logic        nrst     = 1'b0;
  logic        mode1    = 1'b0;
  logic        mode2    = 1'b0;
  logic        trst_n   = 1'b1;
  logic        frame    = 1'b0;
  logic [12:0] dl_data  = 13'h0000;
  logic        dl_valid = 1'b0;
  logic        ul_ready = 1'b0;
  logic        dl_take  = 1'b0;
  wire logic   dl_ready, ul_valid, sclk, hs_data, tst_data, codec_rst, tc_rst;
  wire logic [12:0] ul_data;
  wire logic [1:0]  mode_out;
  logic [12:0] model_dl[$];
  logic [12:0] model_ul[$];
  logic [12:0] got_ul[$];
  int          n_errors    = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          dl_left = 1;
  int          n_fall = 0;
  int          n_tc = 0;
  time         t_fall = 0;
  time         gap = 0;
  always #50 clk = ~clk;
  stsp_port dut_u (.CLOCK_IN(clk), .NRST_IN(nrst), .MODE1_IN(mode1), .MODE2_IN(mode2), .TEST_RST_N_IN(trst_n),
    .TESTER_DATA_IN(tst_data), .MSG_MODE_IN(2'h0), .BLOCK_FRAME_IN(frame), .DL_DATA_IN(dl_data),
    .DL_VALID_IN(dl_valid), .DL_READY_OUT(dl_ready), .UL_DATA_OUT(ul_data), .UL_VALID_OUT(ul_valid),
    .UL_READY_IN(ul_ready), .SCLK_OUT(sclk), .HANDSET_DATA_OUT(hs_data), .MODE_OUT(mode_out),
    .CODEC_RST_OUT(codec_rst), .TRANSCODER_RST_OUT(tc_rst));
  stsp_tester tst_u (.sclk_in(sclk), .nrst_in(nrst), .data_in(hs_data), .data_out(tst_data));
  always @(negedge clk) begin
    dl_take = dl_ready & dl_valid;
    if (ul_valid & ul_ready) got_ul.push_back(ul_data);
    if (tc_rst === 1'b1) n_tc++;
  end
  always @(negedge sclk) begin
    n_fall++;
    if (n_fall == 2) gap = $time - t_fall;
    t_fall = $time;
  end
  // Sample source: holds each word until the port takes it
  always @(posedge clk) begin
    if (dl_take) begin
      model_dl.push_back(dl_data);
      dl_left--;
    end
    if (dl_left > 0 && (dl_take || !dl_valid)) begin
      dl_data  <= 13'($urandom);
      dl_valid <= 1'b1;
    end else if (dl_take) dl_valid <= 1'b0;
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: saw %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic set_mode(input logic [1:0] m);
    @(posedge clk);
    mode1  <= m[1];
    mode2  <= m[0];
    trst_n <= 1'b0; // Pulse kept short: the port does not time it
    repeat (10) @(posedge clk);
    check(codec_rst, 1'b1);
    tst_u.rx_q.delete();
    tst_u.nbit = 0;
    n_fall = 0;
    n_tc = 0;
    trst_n <= 1'b1;
    repeat (10) @(negedge clk);
    check(n_tc, (m != 2'h0) ? 1 : 0);
    check(mode_out, m);
    check(codec_rst, 1'b0);
  endtask
  task automatic add_ul(input int n);
    logic [12:0] w;
    repeat (n) begin
      w = 13'($urandom);
      model_ul.push_back(w);
      tst_u.tx_q.push_back(w);
    end
    repeat (300) @(posedge clk);
    check(n_fall, 0);
    frame <= 1'b1;
    @(posedge clk);
    frame <= 1'b0;
  endtask
  task automatic wait_for(input int n_rx, input int n_ul);
    for (int i = 0; i < 9000 && (tst_u.rx_q.size() < n_rx || got_ul.size() < n_ul); i++) @(posedge clk);
    repeat (60) @(negedge clk);
  endtask
  initial begin
    void'($urandom(31018));
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    set_mode(2'h0);
    add_ul(0);
    repeat (300) @(posedge clk);
    check(n_fall, 0);
    check(sclk, SCLK_IDLE);
    set_mode(2'h1);
    dl_left += 2;
    wait_for(3, 0);
    check(gap, 2 * HALF_CYC * 100);
    foreach (model_dl[i]) check(tst_u.rx_q[i], model_dl[i]);
    model_dl.delete();
    set_mode(2'h2);
    add_ul(3);
    repeat (4000) @(posedge clk);
    check(tst_u.tx_q.size(), 1); // Full buffer refuses a third word
    check(ul_valid, 1'b1);
    ul_ready <= 1'b1;
    wait_for(0, 3);
    foreach (model_ul[i]) check(got_ul[i], model_ul[i]);
    check(sclk, SCLK_IDLE);
    got_ul.delete();
    model_ul.delete();
    set_mode(2'h3);
    add_ul(2);
    dl_left = 2;
    wait_for(2, 2);
    foreach (model_ul[i]) check(got_ul[i], model_ul[i]);
    foreach (model_dl[i]) check(tst_u.rx_q[i], model_dl[i]);
    check(sclk, SCLK_IDLE);
    report_and_stop();
  end
endmodule
